/* File: rtl/wsr_pkg.sv */
// Shared constants for the wheel speed report scheduler
package wsr_pkg;
  // Core clock rate, whole megahertz
  localparam int CLK_MHZ = 10;
  // Nominal wheel capture period, microseconds
  localparam int CAP_PERIOD_US = 10000;
  localparam int CAP_PERIOD_CYC = CAP_PERIOD_US * CLK_MHZ;
  // Trigger to message complete, longest, microseconds
  localparam int TX_DEADLINE_US = 1900;
  localparam int TX_DEADLINE_CYC = TX_DEADLINE_US * CLK_MHZ;
  // Diagnostic packet period, microseconds
  localparam int DIAG_PERIOD_US = 50000;
  localparam int DIAG_PERIOD_CYC = DIAG_PERIOD_US * CLK_MHZ;
  // Timer width covers the longest period
  localparam int TMR_W = 20;
  // Wheel channels and frame numbering
  localparam int WHEELS = 4;
  localparam logic [1:0] LAST_FRAME = 2'h3;
  // Diagnostic packet layout
  localparam int PKT_W = 8;
  localparam int TC_IDX_W = 5;
  localparam int TC_ST_W = 3;
  localparam int TC_IDX_LSB = 3;
  localparam int TC_ST_LSB = 0;
  localparam int TC_COUNT = 32;
  localparam logic [TC_IDX_W-1:0] TC_IDX_RESET = 5'h00;
  // Supported monitors: sensor circuit and signal faults, memory faults
  localparam logic [TC_COUNT-1:0] TC_SUPPORTED = 32'h000effff;
  // Status encoding
  typedef enum logic [TC_ST_W-1:0] {
    WSR_ST_NOT_SUPPORTED = 3'h0,
    WSR_ST_CRIT_DISABLED = 3'h1,
    WSR_ST_NO_REPORT = 3'h2,
    WSR_ST_PASSED = 3'h3,
    WSR_ST_FAILED = 3'h4
  } wsr_status_t;
  // Sequence number reset value
  localparam logic [1:0] SEQ_RESET = 2'h0;
endpackage : wsr_pkg

/* File: rtl/wsr_scheduler.sv */
// Wheel speed capture, grouped frame send and rolling diagnostic packet
// Function
// - Capture wheel data at fixed nominal period
// - All channels captured inside one window
// - Frames of one sample consecutive, same sequence
// - Fresh frame set arbitrated once per period
// - Finish one set before next begins
// - Sample to send end below 2 ms
// - Trigger within 0.6 ms of capture
// - Message complete within 1.9 ms of trigger
// - Packet is 5-bit index, 3-bit status
// - Status codes 0 to 4 as defined
// - Step all 32 indices, one per packet
// - Unsupported indices still sent, status zero
// - Start at index 0, wrap after 31
// - Diagnostic packet every 50 ms
// - Advance index only at packet period
// - Refresh outgoing contents within 70 ms
// - Indices 0 to 4 name sensor circuit faults
// - Sequence number rolls 0 to 3
// - Supported codes start at no report
module wsr_scheduler #(
  parameter int COUNT_W = 16,
  parameter int STAMP_W = 16,
  parameter int CAP_CYC = wsr_pkg::CAP_PERIOD_CYC,
  parameter int DEADLINE_CYC = wsr_pkg::TX_DEADLINE_CYC,
  parameter int DIAG_CYC = wsr_pkg::DIAG_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [wsr_pkg::WHEELS*COUNT_W-1:0] wheel_count,
  input wire logic [wsr_pkg::WHEELS*STAMP_W-1:0] wheel_stamp,
  input wire logic tx_done,
  input wire logic diag_done,
  input wire logic status_wr,
  input wire logic [wsr_pkg::TC_IDX_W-1:0] status_idx,
  input wire logic [wsr_pkg::TC_ST_W-1:0] status_val,
  output logic cap_strobe,
  output logic tx_trigger,
  output logic tx_req,
  output logic [1:0] tx_frame,
  output logic [1:0] tx_seq,
  output logic [COUNT_W-1:0] tx_count,
  output logic [STAMP_W-1:0] tx_stamp,
  output logic diag_req,
  output logic [wsr_pkg::PKT_W-1:0] diag_data,
  output logic overrun,
  output logic late
);

  typedef enum logic [1:0] {
    WSR_IDLE,
    WSR_TRIG,
    WSR_SEND
  } wsr_state_t;

  wsr_state_t state;
  logic [wsr_pkg::TMR_W-1:0] cap_tmr;
  logic [wsr_pkg::TMR_W-1:0] diag_tmr;
  logic [wsr_pkg::TMR_W-1:0] dl_cnt;
  logic [COUNT_W-1:0] cnt_hold [wsr_pkg::WHEELS];
  logic [STAMP_W-1:0] stamp_hold [wsr_pkg::WHEELS];
  logic [wsr_pkg::TC_ST_W-1:0] store [wsr_pkg::TC_COUNT];
  logic [wsr_pkg::TC_IDX_W-1:0] tc_idx;
  logic diag_pend;
  logic cap_tick;
  logic diag_tick;
  logic [1:0] next_frame;

  // Reset value of one store entry
  function automatic logic [wsr_pkg::TC_ST_W-1:0] init_status(input int idx);
    init_status = wsr_pkg::TC_SUPPORTED[idx] ? wsr_pkg::WSR_ST_NO_REPORT : wsr_pkg::WSR_ST_NOT_SUPPORTED;
  endfunction : init_status

  assign cap_tick = (cap_tmr == '0);
  assign diag_tick = (diag_tmr == '0);
  assign next_frame = tx_frame + 2'h1;

  // Free-running capture period timer
  always_ff @(posedge core_clk) begin
    if (srst || cap_tick) begin
      cap_tmr <= wsr_pkg::TMR_W'(CAP_CYC - 1);
    end else begin
      cap_tmr <= cap_tmr - wsr_pkg::TMR_W'(1);
    end
  end

  // Frame scheduler; one capture per period, held off while a set is in flight
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= WSR_IDLE;
    end else begin
      case (state)
        WSR_IDLE: begin
          if (cap_tick) begin
            state <= WSR_TRIG;
          end
        end
        WSR_TRIG: begin
          state <= WSR_SEND;
        end
        WSR_SEND: begin
          if (tx_done && tx_frame == wsr_pkg::LAST_FRAME) begin
            state <= WSR_IDLE;
          end
        end
        default: begin
          state <= WSR_IDLE;
        end
      endcase
    end
  end

  // Snapshot every channel on one edge, so the window is a single cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < wsr_pkg::WHEELS; i++) begin
        cnt_hold[i] <= '0;
        stamp_hold[i] <= '0;
      end
    end else if (state == WSR_IDLE && cap_tick) begin
      for (int i = 0; i < wsr_pkg::WHEELS; i++) begin
        cnt_hold[i] <= wheel_count[i*COUNT_W +: COUNT_W];
        stamp_hold[i] <= wheel_stamp[i*STAMP_W +: STAMP_W];
      end
    end
  end

  // Capture strobe and rolling sequence number
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_strobe <= 1'b0;
      tx_seq <= wsr_pkg::SEQ_RESET;
    end else begin
      cap_strobe <= (state == WSR_IDLE) && cap_tick;
      if (state == WSR_IDLE && cap_tick) begin
        tx_seq <= tx_seq + 2'h1;
      end
    end
  end

  // Trigger follows capture by one cycle, far inside the allowed delay
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_trigger <= 1'b0;
    end else begin
      tx_trigger <= (state == WSR_TRIG);
    end
  end

  // Request held across all four frames, next frame on each completion
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_req <= 1'b0;
      tx_frame <= 2'h0;
      tx_count <= '0;
      tx_stamp <= '0;
    end else if (state == WSR_TRIG) begin
      tx_req <= 1'b1;
      tx_frame <= 2'h0;
      tx_count <= cnt_hold[0];
      tx_stamp <= stamp_hold[0];
    end else if (state == WSR_SEND && tx_done) begin
      if (tx_frame == wsr_pkg::LAST_FRAME) begin
        tx_req <= 1'b0;
      end else begin
        tx_frame <= next_frame;
        tx_count <= cnt_hold[next_frame];
        tx_stamp <= stamp_hold[next_frame];
      end
    end
  end

  // Deadline watch from trigger to last completion
  always_ff @(posedge core_clk) begin
    if (srst || state == WSR_IDLE) begin
      dl_cnt <= '0;
    end else if (dl_cnt != wsr_pkg::TMR_W'(DEADLINE_CYC)) begin
      dl_cnt <= dl_cnt + wsr_pkg::TMR_W'(1);
    end
  end

  // Sticky faults; only reset clears them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      late <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (state == WSR_SEND && dl_cnt == wsr_pkg::TMR_W'(DEADLINE_CYC)) begin
        late <= 1'b1;
      end
      if (state != WSR_IDLE && cap_tick) begin
        overrun <= 1'b1;
      end
    end
  end

  // Diagnostic period timer; a late completion defers, never doubles up
  always_ff @(posedge core_clk) begin
    if (srst || diag_tick) begin
      diag_tmr <= wsr_pkg::TMR_W'(DIAG_CYC - 1);
    end else begin
      diag_tmr <= diag_tmr - wsr_pkg::TMR_W'(1);
    end
  end

  // Pending flag; tick wins over the launch that clears it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      diag_pend <= 1'b0;
    end else if (diag_tick) begin
      diag_pend <= 1'b1;
    end else if (diag_pend && !diag_req) begin
      diag_pend <= 1'b0;
    end
  end

  // Packet launch reads the store entry for the current index
  always_ff @(posedge core_clk) begin
    if (srst) begin
      diag_req <= 1'b0;
      diag_data <= '0;
    end else if (diag_req) begin
      if (diag_done) begin
        diag_req <= 1'b0;
      end
    end else if (diag_pend) begin
      diag_req <= 1'b1;
      diag_data[wsr_pkg::TC_IDX_LSB +: wsr_pkg::TC_IDX_W] <= tc_idx;
      diag_data[wsr_pkg::TC_ST_LSB +: wsr_pkg::TC_ST_W] <= store[tc_idx];
    end
  end

  // Index steps only on a completed packet, wrapping by width
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tc_idx <= wsr_pkg::TC_IDX_RESET;
    end else if (diag_req && diag_done) begin
      tc_idx <= tc_idx + wsr_pkg::TC_IDX_W'(1);
    end
  end

  // Status store; entries 0..4 are the sensor circuit monitors
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < wsr_pkg::TC_COUNT; i++) begin
        store[i] <= init_status(i);
      end
    end else begin
      // A reported decision re-arms the monitor to its power-up value
      if (diag_req && diag_done && diag_data[wsr_pkg::TC_ST_W-1:0] >= wsr_pkg::WSR_ST_PASSED) begin
        store[tc_idx] <= init_status(int'(tc_idx));
      end
      // Fresh monitor result wins over the re-arm; unsupported slots stay zero
      if (status_wr && wsr_pkg::TC_SUPPORTED[status_idx] && status_val <= wsr_pkg::WSR_ST_FAILED) begin
        store[status_idx] <= status_val;
      end
    end
  end

  // Helper: cycles since the previous capture strobe
  logic [wsr_pkg::TMR_W-1:0] cap_gap;
  logic cap_seen;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_gap <= '0;
      cap_seen <= 1'b0;
    end else if (cap_strobe) begin
      cap_gap <= '0;
      cap_seen <= 1'b1;
    end else if (cap_tick && state != WSR_IDLE) begin
      // Skipped tick restarts the count; all ones reads zero a cycle on, as after a strobe
      cap_gap <= '1;
    end else begin
      cap_gap <= cap_gap + wsr_pkg::TMR_W'(1);
    end
  end

  // Helper: cycles since the previous packet launch
  logic [wsr_pkg::TMR_W-1:0] diag_gap;
  logic diag_seen;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      diag_gap <= '0;
      diag_seen <= 1'b0;
    end else if (diag_req && !$past(diag_req)) begin
      diag_gap <= '0;
      diag_seen <= 1'b1;
    end else if (diag_gap != '1) begin
      diag_gap <= diag_gap + wsr_pkg::TMR_W'(1);
    end
  end

  // Checks on the core clock; reset holds them off
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  capture_period_a: assert property (cap_strobe && cap_seen |-> cap_gap == wsr_pkg::TMR_W'(CAP_CYC - 1))
    else $error("capture spacing differs from period");
  trigger_delay_a: assert property (cap_strobe |=> tx_trigger && tx_req && tx_frame == 2'h0)
    else $error("trigger not one cycle after capture");
  seq_stable_a: assert property (tx_req && $past(tx_req) |-> $stable(tx_seq))
    else $error("sequence changed inside a frame set");
  seq_roll_a: assert property (cap_strobe |-> tx_seq == $past(tx_seq) + 2'h1)
    else $error("sequence did not advance by one");
  frame_step_a: assert property (
    tx_req && tx_done && tx_frame != 2'h3 |=> tx_req && tx_frame == $past(tx_frame) + 2'h1)
    else $error("frames not back to back");
  set_end_a: assert property (tx_req && tx_done && tx_frame == 2'h3 |=> !tx_req ##1 !tx_trigger)
    else $error("set did not close after last frame");
  late_flag_a: assert property (tx_req && dl_cnt == wsr_pkg::TMR_W'(DEADLINE_CYC) |=> late)
    else $error("missed deadline not flagged");
  diag_step_a: assert property (diag_req && diag_done |=> tc_idx == $past(tc_idx) + 5'h01 && !diag_req)
    else $error("index did not step on completion");
  diag_spacing_a: assert property (
    $rose(diag_req) && diag_seen |-> diag_gap >= wsr_pkg::TMR_W'(DIAG_CYC - 1))
    else $error("packet sent faster than period");
  unsupported_zero_a: assert property (
    $rose(diag_req) && !wsr_pkg::TC_SUPPORTED[diag_data[7:3]] |-> diag_data[2:0] == 3'h0)
    else $error("unsupported index sent nonzero status");
  status_range_a: assert property (diag_req |-> diag_data[2:0] <= 3'h4)
    else $error("status code out of range");
  first_index_a: assert property ($fell(srst) |-> tc_idx == 5'h00 throughout (!diag_req [*1]))
    else $error("index not zero after reset");
  skip_capture_a: assert property (cap_tick && state != WSR_IDLE |=> !cap_strobe && overrun)
    else $error("busy capture tick not skipped");
  trigger_pulse_a: assert property (tx_trigger |=> !tx_trigger)
    else $error("trigger longer than one cycle");
  diag_hold_a: assert property (diag_req && !diag_done |=> diag_req && $stable(diag_data))
    else $error("packet changed before completion");

  set_sent_c: cover property (tx_req && tx_done && tx_frame == 2'h3);
  index_wrap_c: cover property (diag_req && diag_done && tc_idx == 5'h1f);
  overrun_c: cover property ($rose(overrun));
  failed_report_c: cover property ($rose(diag_req) ##0 diag_data[2:0] == 3'h4);
  passed_report_c: cover property (diag_req && diag_done && diag_data[2:0] == 3'h3);

endmodule : wsr_scheduler

/* File: tb/wsr_rx_model.sv */
// Powertrain receiver model: acknowledges frames and logs trouble code status
module wsr_rx_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tx_req,
  input wire logic diag_req,
  input wire logic [7:0] diag_data,
  input wire logic [7:0] tx_wait,
  input wire logic [7:0] diag_wait,
  output logic tx_done,
  output logic diag_done
);
  logic [7:0] tx_cnt;
  logic [7:0] diag_cnt;
  logic [7:0] last_pkt;
  logic have_last;
  logic [2:0] code_st [32];

  // Frame accepted after a programmable wait; a long wait models a busy bus
  always_ff @(posedge core_clk) begin
    if (srst || !tx_req || tx_done) begin
      tx_cnt <= 8'h00;
      tx_done <= 1'b0;
    end else if (tx_cnt >= tx_wait) begin
      tx_done <= 1'b1;
    end else begin
      tx_cnt <= tx_cnt + 8'h01;
    end
  end

  // Diagnostic packet accepted the same way
  always_ff @(posedge core_clk) begin
    if (srst || !diag_req || diag_done) begin
      diag_cnt <= 8'h00;
      diag_done <= 1'b0;
    end else if (diag_cnt >= diag_wait) begin
      diag_done <= 1'b1;
    end else begin
      diag_cnt <= diag_cnt + 8'h01;
    end
  end

  // Status log; a missed index is never written, so it keeps its old value
  always_ff @(posedge core_clk) begin
    if (srst) begin
      have_last <= 1'b0;
      last_pkt <= 8'h00;
    end else if (diag_req && diag_done) begin
      if (!have_last || diag_data != last_pkt) begin
        code_st[diag_data[7:3]] <= diag_data[2:0];
      end
      have_last <= 1'b1;
      last_pkt <= diag_data;
    end
  end
endmodule : wsr_rx_model

/* File: tb/wsr_scheduler_tb_top.sv */
// Self-checking bench for the wheel speed report scheduler
module wsr_scheduler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run brief
  localparam int CAP = 40;
  localparam int DLN = 30;
  localparam int DIAG = 60;
  localparam logic [4:0] WR_IDX [5] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h14};
  localparam logic [2:0] WR_VAL [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h1};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [63:0] wheel_count = 64'h0;
  logic [63:0] wheel_stamp = 64'h0;
  logic status_wr = 1'b0;
  logic [4:0] status_idx = 5'h00;
  logic [2:0] status_val = 3'h0;
  logic [7:0] tx_wait = 8'h01;
  logic tx_done, diag_done, cap_strobe, tx_trigger, tx_req, diag_req, overrun, late;
  logic diag_q = 1'b0;
  logic [1:0] tx_frame, tx_seq;
  logic [15:0] tx_count, tx_stamp;
  logic [7:0] diag_data;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] pkts [$];
  int rises [$];

  // Clock, 100 ns period
  always #50 core_clk = ~core_clk;

  wsr_scheduler #(.CAP_CYC(CAP), .DEADLINE_CYC(DLN), .DIAG_CYC(DIAG)) dut (
    .core_clk(core_clk), .srst(srst), .wheel_count(wheel_count), .wheel_stamp(wheel_stamp),
    .tx_done(tx_done), .diag_done(diag_done), .status_wr(status_wr), .status_idx(status_idx),
    .status_val(status_val), .cap_strobe(cap_strobe), .tx_trigger(tx_trigger), .tx_req(tx_req),
    .tx_frame(tx_frame), .tx_seq(tx_seq), .tx_count(tx_count), .tx_stamp(tx_stamp),
    .diag_req(diag_req), .diag_data(diag_data), .overrun(overrun), .late(late));

  wsr_rx_model rx (.core_clk(core_clk), .srst(srst), .tx_req(tx_req), .diag_req(diag_req),
    .diag_data(diag_data), .tx_wait(tx_wait), .diag_wait(8'h02), .tx_done(tx_done), .diag_done(diag_done));

  // Packet log; pre-edge values, so no race with the design's updates
  always @(posedge core_clk) begin
    cyc++;
    if (!srst && diag_req && diag_done) pkts.push_back(diag_data);
    if (!srst && diag_req && !diag_q) rises.push_back(cyc);
    diag_q = diag_req;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Distinct values per set and wheel so a stale or swapped frame shows
  task automatic set_wheels(input int k);
    for (int w = 0; w < 4; w++) begin
      wheel_count[w*16 +: 16] <= 16'(k * 256 + w);
      wheel_stamp[w*16 +: 16] <= 16'(16'hf000 - k * 16 - w);
    end
  endtask : set_wheels

  // Second pass: a reported pass or fail has re-armed to no report
  function automatic logic [2:0] exp_st(input int j);
    case (j)
      1, 33: return 3'h1;
      2: return 3'h3;
      3: return 3'h4;
      default: return wsr_pkg::TC_SUPPORTED[j % 32] ? 3'h2 : 3'h0;
    endcase
  endfunction : exp_st

  task automatic reset_scenario;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    set_wheels(1);
    @(posedge core_clk);
    #1;
    check("idle outputs", 32'h0, 32'({cap_strobe, tx_req, diag_req, diag_data, overrun, late}));
    // Writes incl. an out-of-range value and an unsupported index, both ignored
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      status_wr <= 1'b1;
      status_idx <= WR_IDX[i];
      status_val <= WR_VAL[i];
    end
    @(posedge core_clk);
    status_wr <= 1'b0;
  endtask : reset_scenario

  task automatic wheel_scenario;
    int t0;
    int tprev;
    int n;
    tprev = 0;
    for (int k = 1; k <= 5; k++) begin
      for (n = 0; n < 100 && cap_strobe !== 1'b1; n++) begin
        @(posedge core_clk);
        #1;
      end
      t0 = cyc;
      if (k > 1) check("capture spacing", CAP, t0 - tprev);
      tprev = t0;
      @(posedge core_clk);
      #1;
      check("trigger after capture", 32'h1, 32'(tx_trigger));
      for (int f = 0; f < 4; f++) begin
        for (n = 0; n < 50 && tx_done !== 1'b1; n++) begin
          @(posedge core_clk);
          #1;
        end
        check("frame number", f, 32'(tx_frame));
        check("trigger pulse", 32'h0, 32'(tx_trigger));
        check("sequence", k % 4, 32'(tx_seq));
        check("pulse count", k * 256 + f, 32'(tx_count));
        check("timestamp", 32'(16'(16'hf000 - k * 16 - f)), 32'(tx_stamp));
        @(posedge core_clk);
        #1;
      end
      check("set finished", 32'h0, 32'(tx_req));
      check("sample to end", 32'h1, 32'(cyc - t0 <= DLN));
      @(posedge core_clk);
      set_wheels(k + 1);
    end
  endtask : wheel_scenario

  task automatic diag_scenario;
    int n;
    // Past the wrap, far enough to see the re-armed entry 2 again
    for (n = 0; n < 2500 && pkts.size() < 35; n++) begin
      @(posedge core_clk);
    end
    check("packets seen", 32'h1, 32'(pkts.size() >= 35));
    for (int j = 0; j < 35 && j < pkts.size(); j++) begin
      check("diag index", 32'(j % 32), 32'(pkts[j][7:3]));
      check("diag status", 32'(exp_st(j)), 32'(pkts[j][2:0]));
      if (j > 0) check("diag spacing", DIAG, rises[j] - rises[j-1]);
    end
  endtask : diag_scenario

  // A slow receiver stretches each set past the deadline and the next tick
  task automatic overrun_scenario;
    int n;
    @(posedge core_clk);
    tx_wait <= 8'h0c;
    for (n = 0; n < 200 && overrun !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    check("overrun flag", 32'h1, 32'(overrun));
    check("late flag", 32'h1, 32'(late));
  endtask : overrun_scenario

  // Watchdog, well past the expected run of about 2200 cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    reset_scenario();
    wheel_scenario();
    diag_scenario();
    overrun_scenario();
    final_report();
  end
endmodule : wsr_scheduler_tb_top
